// ==== rtl/ecb_pkg.sv ====
// Shared constants and types for the embedded memory block in search-memory mode
package ecb_pkg;

    // ========================================================================
    // Geometry
    // ========================================================================
    localparam int ECB_WORDS     = 32;  // Stored words
    localparam int ECB_WIDTH     = 32;  // Bits per word
    localparam int ECB_ADDR_W    = 5;   // Encoded address width
    localparam int ECB_LINE_W    = 16;  // Unencoded output bus width
    localparam int ECB_HALF_BASE = 16;  // First word shown in the second half

    // ========================================================================
    // Timing counts, in port enable steps
    // ========================================================================
    localparam int ECB_WR_STEPS_PLAIN  = 2;  // Capture plus data commit
    localparam int ECB_WR_STEPS_MASKED = 3;  // Plus the care-mask commit

    // ========================================================================
    // Reset values
    // ========================================================================
    localparam logic [ECB_WIDTH-1:0]  ECB_CARE_ALL   = 32'hFFFFFFFF;  // Every bit compared
    localparam logic [ECB_WIDTH-1:0]  ECB_WORD_RST   = 32'h00000000;  // Default loaded word
    localparam logic [ECB_ADDR_W-1:0] ECB_ADDR_RST   = 5'h00;         // Idle address
    localparam logic [ECB_LINE_W-1:0] ECB_LINES_RST  = 16'h0000;      // Idle match lines
    localparam logic [ECB_WORDS-1:0]  ECB_VEC_RST    = 32'h00000000;  // No matches

    // ========================================================================
    // Types
    // ========================================================================
    typedef logic [ECB_WIDTH-1:0] ecb_word_t;  // One stored word
    typedef logic [ECB_WORDS-1:0] ecb_vec_t;   // One match line per word

    typedef enum logic [1:0] {WR_IDLE, WR_STORE, WR_MASK} ecb_wr_e;               // Write port
    typedef enum logic [2:0] {SR_IDLE, SR_CMP, SR_PIPE, SR_EMIT, SR_HIGH} ecb_sr_e; // Search port

endpackage

// ==== rtl/ecb_cam.sv ====
// Search-memory mode of the embedded memory block: 32 x 32 with per-bit don't-care
//
// Function
// - Hold 32 words of 32 bits, compare all.
// - Don't-care bits never block a match.
// - Encoded option gives matching word's binary address.
// - Unencoded option shows 32 words over two cycles.
// - Duplicates: encoded unreliable, unencoded flags all.
// - Write takes two steps, three with don't-care.
// - Contents preloaded at configuration, writable in operation.
// - Input registers on writes, optional output stage.
// - Write and search ports run at different rates.
`timescale 1ns/100ps
`default_nettype none

module ecb_cam
    import ecb_pkg::*;
#(
    parameter ecb_word_t INIT_WORDS [ECB_WORDS] = '{default: ECB_WORD_RST},  // Configuration image
    parameter ecb_word_t INIT_CARE  [ECB_WORDS] = '{default: ECB_CARE_ALL}   // Configuration care masks
)(
    input  wire logic                  CORE_CLK,     // 25 MHz core clock
    input  wire logic                  RST_B,        // Asynchronous reset, active low
    input  wire logic                  WR_CLK_EN,    // Write port step enable
    input  wire logic                  WR_REQ,       // Write request
    input  wire logic [ECB_ADDR_W-1:0] WR_ADDR,      // Word to write
    input  wire logic [ECB_WIDTH-1:0]  WR_DATA,      // Data to store
    input  wire logic [ECB_WIDTH-1:0]  WR_CARE,      // 1 = compare bit, 0 = don't-care
    input  wire logic                  WR_MASKED,    // Write carries don't-care bits
    output logic                       WR_READY,     // Write port idle
    input  wire logic                  SRCH_CLK_EN,  // Search port step enable
    input  wire logic                  SRCH_REQ,     // Search request
    input  wire logic [ECB_WIDTH-1:0]  SRCH_DATA,    // Search key
    input  wire logic                  ENC_MODE,     // 1 = encoded, 0 = unencoded
    input  wire logic                  OUT_REG_EN,   // Add output pipeline stage
    output logic                       SRCH_READY,   // Search port idle
    output logic                       MATCH_VALID,  // Result pulse
    output logic                       MATCH_FOUND,  // Any word matched
    output logic                       MATCH_MULTI,  // More than one word matched
    output logic [ECB_ADDR_W-1:0]      MATCH_ADDR,   // Encoded address
    output logic [ECB_LINE_W-1:0]      MATCH_LINES,  // Unencoded match lines
    output logic                       MATCH_HALF    // 0 = words 0-15, 1 = words 16-31
);

    // ========================================================================
    // Functions
    // ========================================================================
    // Compare key with every word; cleared care bits are ignored
    function automatic ecb_vec_t match_vec(input ecb_word_t key,
                                           input ecb_word_t mem [ECB_WORDS],
                                           input ecb_word_t care [ECB_WORDS]);
        ecb_vec_t v;
        v = ECB_VEC_RST;
        for (int i = 0; i < ECB_WORDS; i++)
        begin
            v[i] = (((mem[i] ^ key) & care[i]) == ECB_WORD_RST);
        end
        return v;
    endfunction

    // Lowest matching index; only meaningful with a single match
    function automatic logic [ECB_ADDR_W-1:0] enc_addr(input ecb_vec_t v);
        logic [ECB_ADDR_W-1:0] a;
        a = ECB_ADDR_RST;
        for (int i = ECB_WORDS - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                a = ECB_ADDR_W'(i);
            end
        end
        return a;
    endfunction

    // ========================================================================
    // Storage and write port
    // ========================================================================
    ecb_word_t             mem_q  [ECB_WORDS];  // Stored words
    ecb_word_t             mem_d  [ECB_WORDS];  // Next stored words
    ecb_word_t             care_q [ECB_WORDS];  // Stored care masks
    ecb_word_t             care_d [ECB_WORDS];  // Next care masks
    ecb_wr_e               wst_q;               // Write state
    ecb_wr_e               wst_d;               // Next write state
    logic [ECB_ADDR_W-1:0] wa_q;                // Input register: address
    logic [ECB_ADDR_W-1:0] wa_d;                // Next address
    ecb_word_t             wd_q;                // Input register: data
    ecb_word_t             wd_d;                // Next data
    ecb_word_t             wc_q;                // Input register: care
    ecb_word_t             wc_d;                // Next care
    logic                  wm_q;                // Input register: masked flag
    logic                  wm_d;                // Next masked flag
    logic                  wrdy_q;              // Write port idle
    logic                  wrdy_d;              // Next idle

    // Write sequencing; captures first so the commit is fully synchronous
    always_comb
    begin
        mem_d  = mem_q;
        care_d = care_q;
        wst_d  = wst_q;
        wa_d   = wa_q;
        wd_d   = wd_q;
        wc_d   = wc_q;
        wm_d   = wm_q;
        wrdy_d = wrdy_q;
        if (WR_CLK_EN)
        begin
            unique case (wst_q)
                WR_IDLE:
                begin
                    // Step one: latch everything into input registers
                    if (WR_REQ)
                    begin
                        wa_d   = WR_ADDR;
                        wd_d   = WR_DATA;
                        wc_d   = WR_CARE;
                        wm_d   = WR_MASKED;
                        wrdy_d = 1'b0;
                        wst_d  = WR_STORE;
                    end
                end
                WR_STORE:
                begin
                    // Step two: commit data, full compare until mask lands
                    mem_d[wa_q]  = wd_q;
                    care_d[wa_q] = ECB_CARE_ALL;
                    if (wm_q)
                    begin
                        wst_d = WR_MASK;
                    end
                    else
                    begin
                        wrdy_d = 1'b1;
                        wst_d  = WR_IDLE;
                    end
                end
                WR_MASK:
                begin
                    // Step three: commit don't-care pattern
                    care_d[wa_q] = wc_q;
                    wrdy_d       = 1'b1;
                    wst_d        = WR_IDLE;
                end
            endcase
        end
    end

    // Storage registers; reset loads the configuration image
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            mem_q  <= INIT_WORDS;
            care_q <= INIT_CARE;
            wst_q  <= WR_IDLE;
            wa_q   <= ECB_ADDR_RST;
            wd_q   <= ECB_WORD_RST;
            wc_q   <= ECB_CARE_ALL;
            wm_q   <= 1'b0;
            wrdy_q <= 1'b1;
        end
        else
        begin
            mem_q  <= mem_d;
            care_q <= care_d;
            wst_q  <= wst_d;
            wa_q   <= wa_d;
            wd_q   <= wd_d;
            wc_q   <= wc_d;
            wm_q   <= wm_d;
            wrdy_q <= wrdy_d;
        end
    end

    // ========================================================================
    // Search port
    // ========================================================================
    ecb_sr_e               sst_q;    // Search state
    ecb_sr_e               sst_d;    // Next search state
    ecb_word_t             key_q;    // Registered key
    ecb_word_t             key_d;    // Next key
    logic                  enc_q;    // Mode latched per search
    logic                  enc_d;    // Next mode
    logic                  pipe_q;   // Output stage latched per search
    logic                  pipe_d;   // Next output stage choice
    ecb_vec_t              vec_q;    // Match vector
    ecb_vec_t              vec_d;    // Next match vector
    logic                  srdy_q;   // Search port idle
    logic                  srdy_d;   // Next idle
    logic                  mv_q;     // Result pulse
    logic                  mv_d;     // Next pulse
    logic                  mf_q;     // Found
    logic                  mf_d;     // Next found
    logic                  mm_q;     // Multiple
    logic                  mm_d;     // Next multiple
    logic [ECB_ADDR_W-1:0] ma_q;     // Address
    logic [ECB_ADDR_W-1:0] ma_d;     // Next address
    logic [ECB_LINE_W-1:0] ml_q;     // Lines
    logic [ECB_LINE_W-1:0] ml_d;     // Next lines
    logic                  mh_q;     // Half flag
    logic                  mh_d;     // Next half flag

    // One search in flight; mode is frozen at acceptance so a toggle cannot tear a result
    always_comb
    begin
        sst_d  = sst_q;
        key_d  = key_q;
        enc_d  = enc_q;
        pipe_d = pipe_q;
        vec_d  = vec_q;
        srdy_d = srdy_q;
        mv_d   = 1'b0;  // Pulse lasts one core cycle
        mf_d   = mf_q;
        mm_d   = mm_q;
        ma_d   = ma_q;
        ml_d   = ml_q;
        mh_d   = mh_q;
        if (SRCH_CLK_EN)
        begin
            unique case (sst_q)
                SR_IDLE:
                begin
                    // Accept key
                    if (SRCH_REQ)
                    begin
                        key_d  = SRCH_DATA;
                        enc_d  = ENC_MODE;
                        pipe_d = OUT_REG_EN;
                        srdy_d = 1'b0;
                        sst_d  = SR_CMP;
                    end
                end
                SR_CMP:
                begin
                    // Compare against current contents; a write mid-search may or may not be seen
                    vec_d = match_vec(key_q, mem_q, care_q);
                    sst_d = pipe_q ? SR_PIPE : SR_EMIT;
                end
                SR_PIPE:
                begin
                    // Optional extra stage
                    sst_d = SR_EMIT;
                end
                SR_EMIT:
                begin
                    // Summary flags and first view
                    mv_d = 1'b1;
                    mf_d = |vec_q;
                    mm_d = (vec_q & (vec_q - 1'b1)) != '0;
                    if (enc_q)
                    begin
                        ma_d   = enc_addr(vec_q);
                        srdy_d = 1'b1;
                        sst_d  = SR_IDLE;
                    end
                    else
                    begin
                        ml_d  = vec_q[ECB_LINE_W-1:0];
                        mh_d  = 1'b0;
                        sst_d = SR_HIGH;
                    end
                end
                SR_HIGH:
                begin
                    // Second view covers the upper words; all duplicates stay visible
                    mv_d   = 1'b1;
                    ml_d   = vec_q[ECB_HALF_BASE +: ECB_LINE_W];
                    mh_d   = 1'b1;
                    srdy_d = 1'b1;
                    sst_d  = SR_IDLE;
                end
            endcase
        end
    end

    // Search registers
    always_ff @(posedge CORE_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sst_q  <= SR_IDLE;
            key_q  <= ECB_WORD_RST;
            enc_q  <= 1'b1;
            pipe_q <= 1'b0;
            vec_q  <= ECB_VEC_RST;
            srdy_q <= 1'b1;
            mv_q   <= 1'b0;
            mf_q   <= 1'b0;
            mm_q   <= 1'b0;
            ma_q   <= ECB_ADDR_RST;
            ml_q   <= ECB_LINES_RST;
            mh_q   <= 1'b0;
        end
        else
        begin
            sst_q  <= sst_d;
            key_q  <= key_d;
            enc_q  <= enc_d;
            pipe_q <= pipe_d;
            vec_q  <= vec_d;
            srdy_q <= srdy_d;
            mv_q   <= mv_d;
            mf_q   <= mf_d;
            mm_q   <= mm_d;
            ma_q   <= ma_d;
            ml_q   <= ml_d;
            mh_q   <= mh_d;
        end
    end

    // ========================================================================
    // Outputs, each straight from a flop
    // ========================================================================
    assign WR_READY    = wrdy_q;
    assign SRCH_READY  = srdy_q;
    assign MATCH_VALID = mv_q;
    assign MATCH_FOUND = mf_q;
    assign MATCH_MULTI = mm_q;
    assign MATCH_ADDR  = ma_q;
    assign MATCH_LINES = ml_q;
    assign MATCH_HALF  = mh_q;

endmodule

`default_nettype wire

// ==== testbench/ecb_cam_assertions.sv ====
// Port checker for the search-memory block
`timescale 1ns/100ps
`default_nettype none
module ecb_cam_assertions (
    input wire logic CORE_CLK,    // Core clock
    input wire logic RST_B,       // Reset, active low
    input wire logic WR_CLK_EN,   // Write step enable
    input wire logic WR_REQ,      // Write request
    input wire logic WR_MASKED,   // Masked write
    input wire logic WR_READY,    // Write idle
    input wire logic SRCH_CLK_EN, // Search step enable
    input wire logic SRCH_REQ,    // Search request
    input wire logic ENC_MODE,    // Encoded result
    input wire logic OUT_REG_EN,  // Pipe stage
    input wire logic SRCH_READY,  // Search idle
    input wire logic MATCH_VALID, // Result pulse
    input wire logic MATCH_FOUND, // Any match
    input wire logic MATCH_MULTI, // Several matches
    input wire logic MATCH_HALF   // Upper half shown
);
    // ==================================================
    // Acceptance strobes
    // ==================================================
    wire logic w_acc = WR_CLK_EN && WR_REQ && WR_READY;       // Write taken
    wire logic s_acc = SRCH_CLK_EN && SRCH_REQ && SRCH_READY; // Search taken
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    // ==================================================
    // Rules
    // ==================================================
    // Write enable may be divided, so wait at most two edges for the next step
    AST_WR_BUSY: assert property (w_acc |=> !WR_READY) else $error("write not busy");
    AST_WR_PLAIN: assert property (first_match(w_acc && !WR_MASKED ##[1:2] WR_CLK_EN) |=> WR_READY)
        else $error("plain write not two steps");
    AST_WR_MASK: assert property (first_match(w_acc && WR_MASKED ##[1:2] WR_CLK_EN) |=> !WR_READY)
        else $error("masked write ended early");
    AST_SR_BUSY: assert property (s_acc |=> !SRCH_READY) else $error("search not busy");
    AST_ENC_LAT: assert property (s_acc && ENC_MODE && !OUT_REG_EN ##1 SRCH_CLK_EN [*2] |=>
        MATCH_VALID && SRCH_READY) else $error("encoded result late");
    AST_UNE_LO: assert property (s_acc && !ENC_MODE && !OUT_REG_EN ##1 SRCH_CLK_EN [*2] |=>
        MATCH_VALID && !MATCH_HALF && !SRCH_READY) else $error("lower half view wrong");
    AST_UNE_HI: assert property (s_acc && !ENC_MODE && !OUT_REG_EN ##1 SRCH_CLK_EN [*3] |=>
        MATCH_VALID && MATCH_HALF && SRCH_READY) else $error("upper half view wrong");
    AST_PIPE: assert property (s_acc && OUT_REG_EN ##1 SRCH_CLK_EN [*3] |->
        !MATCH_VALID ##1 MATCH_VALID) else $error("pipe stage missing");
    AST_MULTI: assert property (MATCH_VALID && MATCH_MULTI |-> MATCH_FOUND) else $error("multi without found");
    AST_VALID_CAUSE: assert property (MATCH_VALID |-> !$past(SRCH_READY)) else $error("result without search");
    // Main scenarios reached
    cover property (s_acc && ENC_MODE);
    cover property (MATCH_VALID && MATCH_HALF);
    cover property (w_acc && WR_MASKED);
    cover property (MATCH_VALID && MATCH_MULTI);
endmodule
bind ecb_cam ecb_cam_assertions chk_u (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .WR_CLK_EN(WR_CLK_EN),
    .WR_REQ(WR_REQ), .WR_MASKED(WR_MASKED), .WR_READY(WR_READY), .SRCH_CLK_EN(SRCH_CLK_EN),
    .SRCH_REQ(SRCH_REQ), .ENC_MODE(ENC_MODE), .OUT_REG_EN(OUT_REG_EN), .SRCH_READY(SRCH_READY),
    .MATCH_VALID(MATCH_VALID), .MATCH_FOUND(MATCH_FOUND), .MATCH_MULTI(MATCH_MULTI), .MATCH_HALF(MATCH_HALF));
`default_nettype wire

// ==== testbench/ecb_user_model.sv ====
// Fabric user logic that writes words into the search memory
`timescale 1ns/100ps
`default_nettype none
module ecb_user_model
    import ecb_pkg::*;
(
    input  wire logic                  clk,       // Core clock
    input  wire logic                  rst_b,     // Reset, active low
    input  wire logic                  go,        // Start one write
    input  wire logic [ECB_ADDR_W-1:0] addr,      // Target word
    input  wire logic [ECB_WIDTH-1:0]  data,      // Word value
    input  wire logic [ECB_WIDTH-1:0]  care,      // Care mask
    input  wire logic                  masked,    // Use care mask
    output logic                       busy,      // Write in progress
    input  wire logic                  wr_ready,  // Device port idle
    input  wire logic                  wr_en,     // Write step enable
    output logic                       wr_req,    // Request
    output logic [ECB_ADDR_W-1:0]      wr_addr,   // Address
    output logic [ECB_WIDTH-1:0]       wr_data,   // Data
    output logic [ECB_WIDTH-1:0]       wr_care,   // Care
    output logic                       wr_masked  // Masked flag
);
    // ==================================================
    // Request, hold until committed, then scramble
    // ==================================================
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy      <= 1'b0;
            wr_req    <= 1'b0;
            wr_addr   <= 5'h00;
            wr_data   <= 32'h00000000;
            wr_care   <= 32'h00000000;
            wr_masked <= 1'b0;
        end
        else if (!busy && go)
        begin
            busy      <= 1'b1;
            wr_req    <= 1'b1;
            wr_addr   <= addr;
            wr_data   <= data;
            wr_care   <= care;
            wr_masked <= masked;
        end
        else if (wr_req && wr_en && wr_ready)
            wr_req <= 1'b0;
        else if (busy && !wr_req && wr_ready)
        begin
            // Fields held through every step, stale values never linger after
            busy      <= 1'b0;
            wr_addr   <= ~wr_addr;
            wr_data   <= ~wr_data;
            wr_care   <= ~wr_care;
            wr_masked <= ~wr_masked;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/embedded_cam_block_tb_top.sv ====
// Self-checking bench for the search-memory block
`timescale 1ns/100ps
`default_nettype none
module embedded_cam_block_tb_top;
    import ecb_pkg::*;
    typedef struct packed {logic [31:0] key; logic enc, pipe, found, multi; logic [4:0] addr; logic [31:0] vec;} ecb_row_s;
    localparam ecb_row_s ROWS [9] = '{
        '{32'h12345678, 1'b1, 1'b0, 1'b1, 1'b0, 5'h0C, 32'h00001000},
        '{32'h12345678, 1'b0, 1'b1, 1'b1, 1'b0, 5'h00, 32'h00001000},
        '{32'hA5A5BEEF, 1'b1, 1'b1, 1'b1, 1'b0, 5'h13, 32'h00080000},
        '{32'hA5A5BEEF, 1'b0, 1'b0, 1'b1, 1'b0, 5'h00, 32'h00080000},
        '{32'h55AA55AA, 1'b0, 1'b0, 1'b1, 1'b1, 5'h00, 32'h10000020},
        '{32'h55AA55AA, 1'b1, 1'b0, 1'b1, 1'b1, 5'h05, 32'h10000020},
        '{32'h0BADF00D, 1'b1, 1'b0, 1'b1, 1'b0, 5'h1F, 32'h80000000},
        '{32'hFFFFFFFF, 1'b1, 1'b1, 1'b0, 1'b0, 5'h00, 32'h00000000},
        '{32'h00000000, 1'b0, 1'b1, 1'b1, 1'b1, 5'h00, 32'h6FF7EFDF}};
    logic core_clk = 0, rst_b = 0, wr_clk_en = 0, srch_clk_en = 1, srch_req = 0, enc_mode = 0, out_reg_en = 0;
    logic go = 0, m_masked = 0, m_busy, wr_req, wr_masked, wr_ready, srch_ready, match_valid, match_found;
    logic match_multi, match_half, f, mu, h0, h1;
    logic [4:0]  m_addr = 0, wr_addr, match_addr, a;
    logic [31:0] m_data = 0, m_care = 0, srch_data = 0, wr_data, wr_care, v;
    logic [15:0] match_lines;
    int error_cnt = 0, samples_checked = 0, n;
    // Write step enable runs at half rate, search at full rate
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) wr_clk_en <= ~wr_clk_en;
    ecb_cam #(.INIT_WORDS('{31: 32'h0BADF00D, default: ECB_WORD_RST}), .INIT_CARE('{default: ECB_CARE_ALL})) dut_u (
        .CORE_CLK(core_clk), .RST_B(rst_b), .WR_CLK_EN(wr_clk_en), .WR_REQ(wr_req), .WR_ADDR(wr_addr),
        .WR_DATA(wr_data), .WR_CARE(wr_care), .WR_MASKED(wr_masked), .WR_READY(wr_ready),
        .SRCH_CLK_EN(srch_clk_en), .SRCH_REQ(srch_req), .SRCH_DATA(srch_data), .ENC_MODE(enc_mode),
        .OUT_REG_EN(out_reg_en), .SRCH_READY(srch_ready), .MATCH_VALID(match_valid), .MATCH_FOUND(match_found),
        .MATCH_MULTI(match_multi), .MATCH_ADDR(match_addr), .MATCH_LINES(match_lines), .MATCH_HALF(match_half));
    ecb_user_model model_u (.clk(core_clk), .rst_b(rst_b), .go(go), .addr(m_addr), .data(m_data), .care(m_care),
        .masked(m_masked), .busy(m_busy), .wr_ready(wr_ready), .wr_en(wr_clk_en), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_care(wr_care), .wr_masked(wr_masked));
    // ==================================================
    // Compare, wait and closing tasks
    // ==================================================
    task automatic chk_bit(string nm, logic got, logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask
    task automatic chk_vec(string nm, logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(string nm);
        chk_bit(nm, 1'b0, 1'b1);
        end_of_test();
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk_bit("wr ready", wr_ready, 1'b1);
        chk_bit("srch ready", srch_ready, 1'b1);
        chk_bit("valid", match_valid, 1'b0);
        @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    // Model holds the write until the device reports the port idle again
    task automatic wr(logic [4:0] ad, logic [31:0] d, logic [31:0] c, logic m);
        @(posedge core_clk);
        go <= 1'b1;
        m_addr <= ad;
        m_data <= d;
        m_care <= c;
        m_masked <= m;
        @(posedge core_clk);
        go <= 1'b0;
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (m_busy !== 1'b0 && n < 20);
        if (n >= 20) tmo("write done");
    endtask
    // One search; the key is scrambled once taken
    task automatic srch(logic [31:0] k, logic e, logic p);
        @(posedge core_clk);
        srch_req <= 1'b1;
        srch_data <= k;
        enc_mode <= e;
        out_reg_en <= p;
        @(posedge core_clk);
        srch_req <= 1'b0;
        srch_data <= ~k;
        n = 0;
        do begin @(posedge core_clk); #1; n++; end while (match_valid !== 1'b1 && n < 20);
        if (n >= 20) tmo("result");
        f = match_found;
        mu = match_multi;
        a = match_addr;
        h0 = match_half;
        h1 = 1'b1;
        v = {16'h0000, match_lines};
        if (!e)
        begin
            @(posedge core_clk);
            #1;
            chk_bit("second view", match_valid, 1'b1);
            v[31:16] = match_lines;
            h1 = match_half;
        end
    endtask
    // ==================================================
    // Main sequence
    // ==================================================
    initial
    begin
        do_reset();
        wr(5'h0C, 32'h12345678, 32'hFFFFFFFF, 1'b0);
        wr(5'h13, 32'hA5A50000, 32'hFFFF0000, 1'b1);
        wr(5'h05, 32'h55AA55AA, 32'hFFFFFFFF, 1'b0);
        wr(5'h1C, 32'h55AA55AA, 32'hFFFFFFFF, 1'b0);
        foreach (ROWS[i])
        begin
            srch(ROWS[i].key, ROWS[i].enc, ROWS[i].pipe);
            chk_bit("found", f, ROWS[i].found);
            chk_bit("multi", mu, ROWS[i].multi);
            chk_vec("latency", 32'(n), 32'(2 + ROWS[i].pipe));
            // Half flag is only refreshed by unencoded results, so it is judged there
            if (ROWS[i].enc)
                chk_vec("addr", {27'h0, a}, {27'h0, ROWS[i].addr});
            else
            begin
                chk_vec("lines", v, ROWS[i].vec);
                chk_bit("half order", {h0, h1} === 2'b01, 1'b1);
            end
            $display("Row %0d done", i);
        end
        // Every bit ignored: the word matches any key
        wr(5'h0A, 32'hDEADBEEF, 32'h00000000, 1'b1);
        srch(32'h12345678, 1'b0, 1'b0);
        chk_vec("lines", v, 32'h00001400);
        $display("Masked-all test done");
        // Reset in mid-run restores the configuration image
        do_reset();
        srch(32'h12345678, 1'b1, 1'b0);
        chk_bit("found", f, 1'b0);
        srch(32'h0BADF00D, 1'b1, 1'b0);
        chk_vec("addr", {27'h0, a}, 32'h0000001F);
        $display("Reset test done");
        end_of_test();
    end
endmodule
`default_nettype wire
